/* File: rtl/tpg_top.sv */
// Test packet generator, checker error readout and frame statistics
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Checker bad-count upper half, frozen on snapshot
// - Count mode zero saturates checker count
// - Fixed mode sends configured byte
// - Mode field picks incrementing, fixed, pseudo-random
// - Pattern valid byte count, six maximum
// - Burst is ten to code; seven continuous
// - 48-bit pattern in three words
// - 48-bit destination match value compared
// - Receive bad check sequence flag
// - Transmit bad check sequence flag
// - 32-bit transmit frame counter, two words
// - 16-bit transmit errored frame counter
// - Ordered read clears transmit statistics
// - 32-bit receive frame counter, two words
// - 16-bit receive errored frame counter
// - Ordered read clears receive statistics
// - Snapshot bit freezes, second bit also clears
// - Checker bad-count lower half below upper
// - Done once all frames with check sent
// - Busy while generator runs
module tpg_top
  import tpg_pkg::*;
(
  input  wire logic           clock,        // Core clock, 100 MHz
  input  wire logic           rst_n,        // Synchronous reset, active low
  input  wire logic [9:0]     reg_addr,     // Register word address
  input  wire logic [15:0]    reg_wdata,    // Write data
  input  wire logic           reg_wr,       // Write strobe
  input  wire logic           reg_rd,       // Read strobe
  output logic [15:0]         reg_rdata,    // Read data, cycle after strobe
  input  wire logic           gen_ready,    // Transmit path takes a byte
  output tpg_byte_t           gen_out,      // Generated byte stream
  input  wire tpg_frame_evt_t tx_evt,       // Frame sent on the line
  input  wire tpg_frame_evt_t rx_evt,       // Frame received from the line
  input  wire logic           chk_bad_frame,// Checker saw an errored frame
  input  wire logic           chk_lock,     // Checker locked on stream
  input  wire logic [47:0]    rx_dest_addr, // Destination of received frame
  input  wire logic           rx_dest_vld,  // Destination address valid
  output logic                da_match,     // Last destination matched
  output logic                da_match_vld  // Pulse with match result
);

  tpg_cfg_t    cfg_q;
  logic [47:0] pattern_q;
  logic [47:0] da_value_q;
  logic        cmode_q;
  logic        start_q;
  logic        stop_q;
  logic [31:0] chk_live_q;
  logic [31:0] chk_snap_q;
  logic [1:0]  fcs_flags_q;
  logic [31:0] tx_cnt_q;
  logic [15:0] tx_err_q;
  logic [31:0] rx_cnt_q;
  logic [15:0] rx_err_q;
  logic [1:0]  tx_seq_q;
  logic [1:0]  rx_seq_q;
  logic        tx_clr;
  logic        rx_clr;
  tpg_state_t  state_q;
  logic [5:0]  idx_q;
  logic [1:0]  fcs_idx_q;
  logic [19:0] left_q;
  logic [31:0] crc_q;
  logic [14:0] prbs_q;
  logic        done_q;
  logic [7:0]  pay_byte;
  logic [7:0]  fcs_byte;
  logic [2:0]  pat_lim;
  logic        wr_chk;
  logic        load;

  assign wr_chk = reg_wr && (reg_addr == A_CHK_STATUS);
  assign load   = !gen_out.valid || gen_ready;   // Output stage free for a new byte

  // One byte step of the reflected frame check
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Software writable configuration
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_q      <= tpg_cfg_t'(REG_RESET);
      pattern_q  <= {3{REG_RESET}};
      da_value_q <= {3{REG_RESET}};
      cmode_q    <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        A_GEN_CFG:  cfg_q <= tpg_cfg_t'(reg_wdata);
        A_PAT_LO:   pattern_q[15:0]  <= reg_wdata;
        A_PAT_MID:  pattern_q[31:16] <= reg_wdata;
        A_PAT_HI:   pattern_q[47:32] <= reg_wdata;
        A_DA_LO:    da_value_q[15:0]  <= reg_wdata;
        A_DA_MID:   da_value_q[31:16] <= reg_wdata;
        A_DA_HI:    da_value_q[47:32] <= reg_wdata;
        A_GEN_CTRL: cmode_q <= reg_wdata[CTRL_CMODE_BIT];
        default:    cmode_q <= cmode_q;
      endcase
    end
  end

  // Start and stop are one-cycle commands, never stored
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else
    begin
      start_q <= reg_wr && (reg_addr == A_GEN_CTRL) && reg_wdata[CTRL_START_BIT];
      stop_q  <= reg_wr && (reg_addr == A_GEN_CTRL) && reg_wdata[CTRL_STOP_BIT];
    end
  end

  // destination compare, result held until next address
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      da_match     <= 1'b0;
      da_match_vld <= 1'b0;
    end
    else
    begin
      da_match_vld <= rx_dest_vld;
      if (rx_dest_vld)
      begin
        da_match <= (rx_dest_addr == da_value_q);
      end
    end
  end

  // Checker errored-frame count, live copy and frozen copy
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      chk_live_q <= 32'h00000000;
      chk_snap_q <= 32'h00000000;
    end
    else
    begin
      // freeze on either bit, clear on the second
      if (wr_chk && (reg_wdata[CHK_SNAP_BIT] || reg_wdata[CHK_SNAPCLR_BIT]))
      begin
        chk_snap_q <= chk_live_q;
      end
      if (wr_chk && reg_wdata[CHK_SNAPCLR_BIT])
      begin
        chk_live_q <= {31'h00000000, chk_bad_frame};
      end
      // stop at all ones in mode zero
      else if (chk_bad_frame && (cmode_q || (chk_live_q != 32'hFFFFFFFF)))
      begin
        chk_live_q <= chk_live_q + 32'h00000001;
      end
    end
  end

  // Check sequence fault flags follow the latest frame of each path
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fcs_flags_q <= 2'b00;
    end
    else
    begin
      if (tx_evt.done)
      begin
        fcs_flags_q[FCS_TX_BIT] <= tx_evt.crc_bad;
      end
      if (rx_evt.done)
      begin
        fcs_flags_q[FCS_RX_BIT] <= rx_evt.crc_bad;
      end
    end
  end

  // Ordered-read trackers; the third read in order clears the group
  assign tx_clr = reg_rd && (reg_addr == A_TX_ERR) && (tx_seq_q == 2'h2);
  assign rx_clr = reg_rd && (reg_addr == A_RX_ERR) && (rx_seq_q == 2'h2);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_seq_q <= 2'h0;
      rx_seq_q <= 2'h0;
    end
    else if (reg_rd)
    begin
      if (reg_addr == A_TX_LO)
        tx_seq_q <= 2'h1;
      else if (reg_addr == A_TX_HI && tx_seq_q == 2'h1)
        tx_seq_q <= 2'h2;
      else if (reg_addr == A_TX_HI || reg_addr == A_TX_ERR)
        tx_seq_q <= 2'h0;
      if (reg_addr == A_RX_LO)
        rx_seq_q <= 2'h1;
      else if (reg_addr == A_RX_HI && rx_seq_q == 2'h1)
        rx_seq_q <= 2'h2;
      else if (reg_addr == A_RX_HI || reg_addr == A_RX_ERR)
        rx_seq_q <= 2'h0;
    end
  end

  // Transmit statistics; a frame in the clearing cycle is kept
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_cnt_q <= 32'h00000000;
      tx_err_q <= 16'h0000;
    end
    else if (tx_clr)
    begin
      tx_cnt_q <= {31'h00000000, tx_evt.done};
      tx_err_q <= {15'h0000, tx_evt.done && tx_evt.crc_bad};
    end
    else if (tx_evt.done)
    begin
      if (tx_cnt_q != 32'hFFFFFFFF)
        tx_cnt_q <= tx_cnt_q + 32'h00000001;
      if (tx_evt.crc_bad && tx_err_q != 16'hFFFF)
        tx_err_q <= tx_err_q + 16'h0001;
    end
  end

  // Receive statistics, same scheme as transmit
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_cnt_q <= 32'h00000000;
      rx_err_q <= 16'h0000;
    end
    else if (rx_clr)
    begin
      rx_cnt_q <= {31'h00000000, rx_evt.done};
      rx_err_q <= {15'h0000, rx_evt.done && rx_evt.crc_bad};
    end
    else if (rx_evt.done)
    begin
      if (rx_cnt_q != 32'hFFFFFFFF)
        rx_cnt_q <= rx_cnt_q + 32'h00000001;
      if (rx_evt.crc_bad && rx_err_q != 16'hFFFF)
        rx_err_q <= rx_err_q + 16'h0001;
    end
  end

  // Payload byte for the current index
  always_comb
  begin
    pat_lim = (cfg_q.pat_bytes > PAT_MAX_BYTES) ? PAT_MAX_BYTES : cfg_q.pat_bytes;
    if (idx_q < {3'h0, pat_lim})
      pay_byte = pattern_q[{idx_q[2:0], 3'h0} +: 8];
    else if (cfg_q.mode[1])
      pay_byte = prbs_q[7:0];
    else if (cfg_q.mode == TPG_MODE_FIXED)
      pay_byte = cfg_q.fixed_byte;
    else
      pay_byte = {2'h0, idx_q};
    fcs_byte = ~crc_q[{fcs_idx_q, 3'h0} +: 8];
  end

  // Generator sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q   <= TPG_IDLE;
      idx_q     <= 6'h00;
      fcs_idx_q <= 2'h0;
      left_q    <= 20'h00000;
      crc_q     <= CRC_INIT;
      prbs_q    <= PRBS_SEED;
      done_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        TPG_IDLE:
        begin
          if (start_q)
          begin
            left_q  <= (cfg_q.burst == BURST_CONT) ? 20'h00000 : BURST_TABLE[cfg_q.burst];
            done_q  <= 1'b0;
            idx_q   <= 6'h00;
            crc_q   <= CRC_INIT;
            state_q <= TPG_PAYLOAD;
          end
        end
        TPG_PAYLOAD:
        begin
          // Step with each byte loaded, so the index names the byte loaded next
          if (load)
          begin
            crc_q  <= crc_step(crc_q, pay_byte);
            prbs_q <= {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
            idx_q  <= idx_q + 6'h01;
            if (idx_q == PAYLOAD_LEN - 6'h01)
            begin
              fcs_idx_q <= 2'h0;
              state_q   <= TPG_FCS;
            end
          end
        end
        TPG_FCS:
        begin
          if (load)
          begin
            fcs_idx_q <= fcs_idx_q + 2'h1;
            if (fcs_idx_q == FCS_LEN_M1)
            begin
              state_q <= TPG_NEXT;
            end
          end
        end
        TPG_NEXT:
        begin
          idx_q <= 6'h00;
          crc_q <= CRC_INIT;
          // done only once the last check byte has been taken
          if (load && ((cfg_q.burst != BURST_CONT && left_q == 20'h00001) || stop_q))
          begin
            done_q  <= 1'b1;
            state_q <= TPG_IDLE;
          end
          else if (load)
          begin
            if (cfg_q.burst != BURST_CONT)
              left_q <= left_q - 20'h00001;
            state_q <= TPG_PAYLOAD;
          end
        end
        default:
        begin
          state_q <= TPG_IDLE;
        end
      endcase
    end
  end

  // Registered byte stream; the byte holds while the path stalls
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      gen_out <= '0;
    end
    else if (load)
    begin
      // Loads the byte the sequencer steps past in this same cycle
      gen_out.valid <= (state_q == TPG_PAYLOAD) || (state_q == TPG_FCS);
      gen_out.last  <= (state_q == TPG_FCS) && (fcs_idx_q == FCS_LEN_M1);
      if (state_q == TPG_FCS)
        gen_out.data <= fcs_byte;
      else if (state_q == TPG_PAYLOAD)
        gen_out.data <= pay_byte;
      else
        gen_out.data <= 8'h00;
    end
  end

  // Registered read data; unmapped words read as zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reg_rdata <= REG_RESET;
    end
    else
    begin
      reg_rdata <= REG_RESET;
      if (reg_rd)
      begin
        case (reg_addr)
          A_CHK_STATUS:
          begin
            reg_rdata[CHK_LOCK_BIT] <= chk_lock;
            reg_rdata[CHK_BUSY_BIT] <= (state_q != TPG_IDLE);
            reg_rdata[CHK_DONE_BIT] <= done_q;
          end
          A_CHK_BAD_LO: reg_rdata <= chk_snap_q[15:0];
          A_CHK_BAD_HI: reg_rdata <= chk_snap_q[31:16];
          A_GEN_CFG:    reg_rdata <= 16'(cfg_q);
          A_PAT_LO:     reg_rdata <= pattern_q[15:0];
          A_PAT_MID:    reg_rdata <= pattern_q[31:16];
          A_PAT_HI:     reg_rdata <= pattern_q[47:32];
          A_DA_LO:      reg_rdata <= da_value_q[15:0];
          A_DA_MID:     reg_rdata <= da_value_q[31:16];
          A_DA_HI:      reg_rdata <= da_value_q[47:32];
          A_FCS_FLAGS:  reg_rdata <= {14'h0000, fcs_flags_q};
          A_TX_LO:      reg_rdata <= tx_cnt_q[15:0];
          A_TX_HI:      reg_rdata <= tx_cnt_q[31:16];
          A_TX_ERR:     reg_rdata <= tx_err_q;
          A_RX_LO:      reg_rdata <= rx_cnt_q[15:0];
          A_RX_HI:      reg_rdata <= rx_cnt_q[31:16];
          A_RX_ERR:     reg_rdata <= rx_err_q;
          A_GEN_CTRL:   reg_rdata[CTRL_CMODE_BIT] <= cmode_q;
          default:      reg_rdata <= REG_RESET;
        endcase
      end
    end
  end

endmodule // tpg_top

`default_nettype wire

/* File: rtl/tpg_pkg.sv */
// Package for the test packet generator and frame statistics block
package tpg_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;

  // Register offsets (word addresses)
  localparam logic [9:0] A_CHK_STATUS     = 10'h11F;
  localparam logic [9:0] A_CHK_BAD_LO     = 10'h121;
  localparam logic [9:0] A_CHK_BAD_HI     = 10'h122;
  localparam logic [9:0] A_GEN_CFG        = 10'h123;
  localparam logic [9:0] A_PAT_LO         = 10'h124;
  localparam logic [9:0] A_PAT_MID        = 10'h125;
  localparam logic [9:0] A_PAT_HI         = 10'h126;
  localparam logic [9:0] A_DA_LO          = 10'h127;
  localparam logic [9:0] A_DA_MID         = 10'h128;
  localparam logic [9:0] A_DA_HI          = 10'h129;
  localparam logic [9:0] A_FCS_FLAGS      = 10'h12A;
  localparam logic [9:0] A_TX_LO          = 10'h12B;
  localparam logic [9:0] A_TX_HI          = 10'h12C;
  localparam logic [9:0] A_TX_ERR         = 10'h12D;
  localparam logic [9:0] A_RX_LO          = 10'h12E;
  localparam logic [9:0] A_RX_HI          = 10'h12F;
  localparam logic [9:0] A_RX_ERR         = 10'h130;
  localparam logic [9:0] A_GEN_CTRL       = 10'h140;

  // Field positions
  localparam int unsigned CHK_SNAP_BIT    = 0;
  localparam int unsigned CHK_SNAPCLR_BIT = 1;
  localparam int unsigned CHK_LOCK_BIT    = 8;
  localparam int unsigned CHK_BUSY_BIT    = 11;
  localparam int unsigned CHK_DONE_BIT    = 12;
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_STOP_BIT   = 1;
  localparam int unsigned CTRL_CMODE_BIT  = 2;
  localparam int unsigned FCS_TX_BIT      = 0;
  localparam int unsigned FCS_RX_BIT      = 1;

  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [2:0]  PAT_MAX_BYTES   = 3'h6;
  localparam logic [2:0]  BURST_CONT      = 3'h7;
  localparam logic [5:0]  PAYLOAD_LEN     = 6'h2E;   // 46 payload bytes
  localparam logic [1:0]  FCS_LEN_M1      = 2'h3;    // 4 check bytes
  localparam logic [31:0] CRC_POLY        = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
  localparam logic [14:0] PRBS_SEED       = 15'h7FFF;

  // Packet count per burst code
  localparam logic [19:0] BURST_TABLE [0:6] = '{20'h00001, 20'h0000A, 20'h00064,
    20'h003E8, 20'h02710, 20'h186A0, 20'hF4240};

  typedef enum logic [1:0] {
    TPG_MODE_INCR  = 2'b00,
    TPG_MODE_FIXED = 2'b01
  } tpg_mode_t;

  typedef struct packed {
    logic [7:0] fixed_byte;
    logic [1:0] mode;
    logic [2:0] pat_bytes;
    logic [2:0] burst;
  } tpg_cfg_t;

  // One finished frame seen by the tx or rx path
  typedef struct packed {
    logic done;
    logic crc_bad;
  } tpg_frame_evt_t;

  // Generated byte stream towards the transmit path
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tpg_byte_t;

  typedef enum logic [1:0] {
    TPG_IDLE    = 2'b00,
    TPG_PAYLOAD = 2'b01,
    TPG_FCS     = 2'b11,
    TPG_NEXT    = 2'b10
  } tpg_state_t;

endpackage : tpg_pkg

/* File: verif/tpg_monitor.sv */
// Assertion checker for the test packet generator block
`timescale 1ns/1ps
`default_nettype none
module tpg_monitor
  import tpg_pkg::*;
(
  input wire logic           clock,         // Core clock
  input wire logic           rst_n,         // Synchronous reset, active low
  input wire logic [9:0]     reg_addr,      // Register address
  input wire logic [15:0]    reg_wdata,     // Write data
  input wire logic           reg_wr,        // Write strobe
  input wire logic           reg_rd,        // Read strobe
  input wire logic [15:0]    reg_rdata,     // Read data
  input wire logic           gen_ready,     // Sink takes a byte
  input wire tpg_byte_t      gen_out,       // Generated bytes
  input wire tpg_frame_evt_t tx_evt,        // Frame sent
  input wire tpg_frame_evt_t rx_evt,        // Frame received
  input wire logic           chk_bad_frame, // Checker errored frame
  input wire logic           chk_lock,      // Checker lock
  input wire logic [47:0]    rx_dest_addr,  // Received destination
  input wire logic           rx_dest_vld,   // Destination valid
  input wire logic           da_match,      // Match result
  input wire logic           da_match_vld   // Match result pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_cfg_echo;
    (reg_wr && reg_addr inside {[A_GEN_CFG:A_DA_HI]}) ##1 (reg_rd && reg_addr == $past(reg_addr))
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_cfg_echo: assert property (p_cfg_echo)
    else $error("configuration word did not read back");

  property p_ro_flags;
    reg_rd && reg_addr == A_FCS_FLAGS |=> reg_rdata[15:2] == 14'h0000;
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("reserved fault flag bits set");

  property p_status_lock;
    reg_rd && reg_addr == A_CHK_STATUS |=> reg_rdata[8] == $past(chk_lock)
      && reg_rdata[7:0] == 8'h00 && reg_rdata[15:13] == 3'h0;
  endproperty
  a_status_lock: assert property (p_status_lock)
    else $error("status word wrong");

  property p_match_pulse;
    rx_dest_vld |=> da_match_vld;
  endproperty
  a_match_pulse: assert property (p_match_pulse)
    else $error("match result missing");

  property p_match_quiet;
    !rx_dest_vld |=> !da_match_vld;
  endproperty
  a_match_quiet: assert property (p_match_quiet)
    else $error("match result without request");

  property p_hold;
    gen_out.valid && !gen_ready |=> gen_out == $past(gen_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed while stalled");

  property p_last_gap;
    gen_out.valid && gen_out.last && gen_ready |=> !gen_out.valid;
  endproperty
  a_last_gap: assert property (p_last_gap)
    else $error("no gap after frame end");
endmodule // tpg_monitor

bind tpg_top tpg_monitor u_mon (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .gen_ready(gen_ready), .gen_out(gen_out), .tx_evt(tx_evt), .rx_evt(rx_evt),
  .chk_bad_frame(chk_bad_frame), .chk_lock(chk_lock), .rx_dest_addr(rx_dest_addr),
  .rx_dest_vld(rx_dest_vld), .da_match(da_match), .da_match_vld(da_match_vld));
`default_nettype wire

/* File: verif/tpg_sink_model.sv */
// Transmit path model that takes generated bytes and reports sent frames
`timescale 1ns/1ps
`default_nettype none
module tpg_sink_model
  import tpg_pkg::*;
(
  input  wire logic       clock,      // Core clock
  input  wire logic       rst_n,      // Synchronous reset, active low
  input  wire tpg_byte_t  gen_out,    // Bytes from the generator
  input  wire logic       slow,       // Take a byte every other cycle
  input  wire logic [7:0] bad_idx,    // Frame number sent with bad check
  output logic            gen_ready,  // Byte taken when high
  output tpg_frame_evt_t  tx_evt,     // Frame sent report
  output logic [7:0]      nframes,    // Frames finished
  output logic [7:0]      flen,       // Length of last frame
  output logic [7:0]      cap [0:49]  // Bytes of the last frame
);
  logic [7:0] pos_q;
  logic       tick_q;

  // Slow mode stalls half the time so the generator must hold its byte
  assign gen_ready = slow ? tick_q : 1'b1;

  // Take bytes, report each frame once its last byte is gone
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pos_q <= 8'h00;
      nframes <= 8'h00;
      flen <= 8'h00;
      tick_q <= 1'b0;
      tx_evt <= '0;
    end
    else
    begin
      tick_q <= ~tick_q;
      tx_evt <= '0;
      if (gen_out.valid && gen_ready)
      begin
        // Guard keeps an overlong frame from writing past the array
        if (pos_q < 8'h32)
          cap[pos_q] <= gen_out.data;
        pos_q <= gen_out.last ? 8'h00 : pos_q + 8'h01;
        if (gen_out.last)
        begin
          flen <= pos_q + 8'h01;
          nframes <= nframes + 8'h01;
          tx_evt.done <= 1'b1;
          tx_evt.crc_bad <= (nframes == bad_idx);
        end
      end
    end
  end
endmodule // tpg_sink_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench for the test packet generator block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tpg_pkg::*;
  logic           clock, rst_n, reg_wr, reg_rd, chk_bad_frame, chk_lock, rx_dest_vld, slow;
  logic           gen_ready, da_match, da_match_vld;
  logic [9:0]     reg_addr;
  logic [15:0]    reg_wdata, reg_rdata, v;
  logic [47:0]    rx_dest_addr;
  logic [7:0]     bad_idx, nframes, flen, cap [0:49];
  tpg_byte_t      gen_out;
  tpg_frame_evt_t tx_evt, rx_evt;
  int             fail_count, check_count;

  tpg_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_ready(gen_ready),
    .gen_out(gen_out), .tx_evt(tx_evt), .rx_evt(rx_evt), .chk_bad_frame(chk_bad_frame),
    .chk_lock(chk_lock), .rx_dest_addr(rx_dest_addr), .rx_dest_vld(rx_dest_vld),
    .da_match(da_match), .da_match_vld(da_match_vld));
  tpg_sink_model u_sink (.clock(clock), .rst_n(rst_n), .gen_out(gen_out), .slow(slow),
    .bad_idx(bad_idx), .gen_ready(gen_ready), .tx_evt(tx_evt), .nframes(nframes),
    .flen(flen), .cap(cap));

  // Clock at 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [9:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [9:0] a, input logic [15:0] e);
    rd(a);
    chk(v, e);
  endtask

  // Write, then read the same word in the very next cycle
  task automatic wrrd(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic t_reset_regs;
    for (logic [9:0] a = A_CHK_STATUS; a <= A_RX_ERR; a++)
      rdc(a, REG_RESET);
    rdc(A_GEN_CTRL, REG_RESET);
  endtask

  // Config, pattern and match words; read-only and unmapped places
  task automatic t_cfg_regs;
    logic [15:0] w [0:6] = '{16'hA5C3, 16'h2211, 16'h4433, 16'h6655, 16'h0B0A, 16'h0D0C,
      16'h0F0E};
    for (int i = 0; i < 7; i++)
    begin
      wrrd(A_GEN_CFG + 10'(i), w[i]);
      chk(v, w[i]);
    end
    wr(A_FCS_FLAGS, 16'hFFFF);
    rdc(A_FCS_FLAGS, 16'h0000);
    wr(A_CHK_BAD_HI, 16'hFFFF);
    rdc(A_CHK_BAD_HI, 16'h0000);
    rdc(10'h3FF, 16'h0000);
  endtask

  task automatic t_da_match(input logic [47:0] da, input logic exp);
    @(posedge clock);
    rx_dest_addr <= da;
    rx_dest_vld <= 1'b1;
    @(posedge clock);
    rx_dest_vld <= 1'b0;
    #1;
    chk(da_match, exp);
  endtask

  // One generator burst, then frame count, length and payload bytes
  task automatic t_gen(input logic [15:0] cfg, input logic s, input logic [7:0] nf);
    logic [7:0] base;
    logic [7:0] e;
    int         pl;
    int         n;
    logic [31:0] c;
    base = nframes;
    slow <= s;
    pl = (cfg[5:3] > 3'h6) ? 6 : int'(cfg[5:3]);
    wr(A_GEN_CFG, cfg);
    wr(A_GEN_CTRL, 16'h0001);
    rd(A_CHK_STATUS);
    chk(v[CHK_BUSY_BIT], 1'b1);
    n = 0;
    while (v[CHK_DONE_BIT] !== 1'b1 && n < 3000)
    begin
      rd(A_CHK_STATUS);
      n++;
    end
    if (n == 3000)
    begin
      fail_count++;
      complete_run();
    end
    chk(v[CHK_BUSY_BIT], 1'b0);
    chk(nframes - base, nf);
    chk(flen, 8'h32);
    c = CRC_INIT;
    for (int i = 0; i < 46 && !cfg[7]; i++)
    begin
      e = (i < pl) ? 8'(48'h665544332211 >> (8 * i)) : (cfg[6] ? cfg[15:8] : 8'(i));
      chk(cap[i], e);
      for (int b = 0; b < 8; b++)
        c = (c[0] ^ e[b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    // Check bytes go out inverted, low byte first
    for (int k = 0; k < 4 && !cfg[7]; k++)
      chk(cap[46 + k], 8'(~c >> (8 * k)));
  endtask

  // Out-of-order reads keep values, ordered reads clear
  task automatic t_tx_stats;
    rdc(A_TX_HI, 16'h0000);
    rdc(A_TX_ERR, 16'h0001);
    rdc(A_TX_LO, 16'h000A);
    rdc(A_TX_HI, 16'h0000);
    rdc(A_FCS_FLAGS, 16'h0001);
    rdc(A_TX_ERR, 16'h0001);
    rdc(A_TX_LO, 16'h0000);
    rdc(A_TX_ERR, 16'h0000);
  endtask

  task automatic rx_frame(input logic bad);
    @(posedge clock);
    rx_evt <= '{done: 1'b1, crc_bad: bad};
    @(posedge clock);
    rx_evt <= '0;
  endtask

  task automatic t_rx_stats;
    rx_frame(1'b0);
    rx_frame(1'b0);
    rx_frame(1'b1);
    rdc(A_FCS_FLAGS, 16'h0002);
    rdc(A_RX_LO, 16'h0003);
    rdc(A_RX_HI, 16'h0000);
    rdc(A_RX_ERR, 16'h0001);
    rdc(A_RX_LO, 16'h0000);
  endtask

  task automatic bad_pulses(input int k);
    repeat (k)
    begin
      @(posedge clock);
      chk_bad_frame <= 1'b1;
      @(posedge clock);
      chk_bad_frame <= 1'b0;
    end
  endtask

  // Snapshot freezes the count, snapshot with clear restarts it
  task automatic t_checker;
    chk_lock <= 1'b1;
    bad_pulses(5);
    wr(A_CHK_STATUS, 16'h0001);
    bad_pulses(2);
    rdc(A_CHK_BAD_LO, 16'h0005);
    rdc(A_CHK_BAD_HI, 16'h0000);
    wr(A_CHK_STATUS, 16'h0002);
    rdc(A_CHK_BAD_LO, 16'h0007);
    wr(A_CHK_STATUS, 16'h0001);
    rdc(A_CHK_BAD_LO, 16'h0000);
    rd(A_CHK_STATUS);
    chk(v[CHK_LOCK_BIT], 1'b1);
    wr(A_GEN_CTRL, 16'h0004);
    rdc(A_GEN_CTRL, 16'h0004);
  endtask

  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    rx_evt = '0;
    chk_bad_frame = 1'b0;
    chk_lock = 1'b0;
    rx_dest_addr = 48'h000000000000;
    rx_dest_vld = 1'b0;
    slow = 1'b0;
    bad_idx = 8'h09;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_regs();
    t_cfg_regs();
    t_da_match(48'h0F0E0D0C0B0A, 1'b1);
    t_da_match(48'h0F0E0D0C0B0B, 1'b0);
    t_gen(16'hA551, 1'b1, 8'h0A);
    t_tx_stats();
    bad_idx = 8'hFF;
    t_gen(16'h0038, 1'b0, 8'h01);
    t_gen(16'h0080, 1'b0, 8'h01);
    t_gen(16'h00C0, 1'b1, 8'h01);
    t_rx_stats();
    t_checker();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
